// file: rtl/bst_pkg.sv
// Purpose: constants shared by the interval timer design files
// Assumes: 8-bit registers, one per aligned APB word at index * 4
// Notes:   register indexes keep the printed offsets of the block
//
// Functional notes
// - 8-bit counter chained into 6-bit, clearable
// - clock select 00 sub, 01 cycle, 11 t0
// - 8-bit overflow clocks 6-bit unless fast mode
// - fast mode: irq0 flag every 64 ticks
// - slow mode: irq0 flag every 16384 ticks
// - run bit 0 stops at zero, 1 runs
// - slow mode irq1 period 32/128/512/2048
// - fast mode irq1 period 32/128/2/8
// - irq1 flag sticky until software writes zero
// - irq0 flag sticky until software writes zero
// - irq1 enable and flag request wake, irq
// - irq0 enable and flag request wake, irq
// - buzzer select: pwm forced high, tone out
// - no buzzer: pwm passed through, pwm to pin
// - pin driven only when function bit set
// - hold-count bit keeps counting during hold
// - period rewrite while running may set irq1
package bst_pkg;
    // register indexes; byte address is four times the index
    localparam int unsigned BST_IDX_SEL  = 32'h0000_fe5f;
    localparam int unsigned BST_IDX_CTL  = 32'h0000_fe7f;
    localparam int unsigned BST_IDX_CNT  = 32'h0000_fe7e;
    localparam int unsigned BST_IDX_AUX  = 32'h0000_fe7d;
    localparam int unsigned BST_AW       = 18;
    localparam logic [17:0] BST_ADDR_SEL = 18'(BST_IDX_SEL * 4);
    localparam logic [17:0] BST_ADDR_CTL = 18'(BST_IDX_CTL * 4);
    localparam logic [17:0] BST_ADDR_CNT = 18'(BST_IDX_CNT * 4);
    localparam logic [17:0] BST_ADDR_AUX = 18'(BST_IDX_AUX * 4);

    // control register fields
    localparam int unsigned BST_CTL_FAST   = 7;
    localparam int unsigned BST_CTL_RUN    = 6;
    localparam int unsigned BST_CTL_P1_HI  = 5;
    localparam int unsigned BST_CTL_P1_LO  = 4;
    localparam int unsigned BST_CTL_IF1    = 3;
    localparam int unsigned BST_CTL_IE1    = 2;
    localparam int unsigned BST_CTL_IF0    = 1;
    localparam int unsigned BST_CTL_IE0    = 0;
    // select register fields
    localparam int unsigned BST_SEL_CK_HI  = 5;
    localparam int unsigned BST_SEL_CK_LO  = 4;
    localparam int unsigned BST_SEL_BUZ    = 3;
    // auxiliary register fields
    localparam int unsigned BST_AUX_HOLDCNT = 0;
    localparam int unsigned BST_AUX_PINFN   = 1;

    // reset values
    localparam logic [7:0] BST_CTL_RST = 8'h00;
    localparam logic [7:0] BST_SEL_RST = 8'h00;
    localparam logic [1:0] BST_AUX_RST = 2'h0;

    // counter widths and buzzer tap (bit 2 toggles every 4 ticks)
    localparam int unsigned BST_LO_W    = 8;
    localparam int unsigned BST_HI_W    = 6;
    localparam int unsigned BST_BUZ_TAP = 2;

    typedef enum logic [1:0] {
        BST_CK_SUB = 2'h0,
        BST_CK_CYC = 2'h1,
        BST_CK_BAD = 2'h2,
        BST_CK_T0  = 2'h3
    } bst_ck_t;
endpackage

// file: rtl/bst_cnt_if.sv
// Purpose: link between the timer core and one counter stage
// Assumes: tick and clear are one-cycle qualifiers on the main clock
// Notes:   wrap is combinational, high on the tick that rolls to zero
`timescale 1ns/1ps
`default_nettype none
interface bst_cnt_if #(parameter int W = 8);
    logic         tick;
    logic         clr;
    logic [W-1:0] value;
    logic         wrap;
    modport ctl (output tick, output clr, input value, input wrap);
    modport cnt (input tick, input clr, output value, output wrap);
endinterface
`default_nettype wire

// file: rtl/bst_upcnt.sv
// Purpose: one binary up-counter stage of the interval timer
// Assumes: synchronous active-low reset
// Notes:   clear beats tick; wrap flags the roll from all ones
`timescale 1ns/1ps
`default_nettype none
module bst_upcnt #(
    parameter int W = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    bst_cnt_if.cnt    port_if
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // next count: clear first, then advance on tick
    always_comb begin
        cnt_next = cnt_reg;
        if (port_if.clr) begin
            cnt_next = '0;
        end else if (port_if.tick) begin
            cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // overflow seen by the next stage and the flag logic
    assign port_if.value = cnt_reg;
    assign port_if.wrap  = port_if.tick & (&cnt_reg) & ~port_if.clr;

    ////////////////////////////////////////////////////////////////////
    property p_cnt_step;
        @(posedge clk_i) disable iff (!rst_n_i)
        (port_if.tick && !port_if.clr)
            |=> port_if.value == W'($past(port_if.value) + 1);
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("counter did not advance on tick");

    property p_cnt_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        port_if.clr |=> port_if.value == '0;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("counter not zero after clear");
endmodule
`default_nettype wire

// file: rtl/bst_timer.sv
// Purpose: 14-bit interval timer with two flags, wake and buzzer
// Assumes: count sources arrive as one-cycle ticks on REF_CLK_I
// Notes:   APB answers one cycle into the access phase
`timescale 1ns/1ps
`default_nettype none
module bst_timer (
    input  wire  logic                        REF_CLK_I,
    input  wire  logic                        RST_N_I,
    input  wire  logic                        PSEL_I,
    input  wire  logic                        PENABLE_I,
    input  wire  logic                        PWRITE_I,
    input  wire  logic [bst_pkg::BST_AW-1:0]  PADDR_I,
    input  wire  logic [31:0]                 PWDATA_I,
    output logic       [31:0]                 PRDATA_O,
    output logic                              PREADY_O,
    output logic                              PSLVERR_O,
    input  wire  logic                        SUBCLK_TICK_I,
    input  wire  logic                        CYCLE_TICK_I,
    input  wire  logic                        T0_PRESCALE_TICK_I,
    input  wire  logic                        XTAL_HOLD_I,
    input  wire  logic                        HIGH_SIDE_PWM_SIGNAL_I,
    output logic                              HIGH_SIDE_PWM_SIGNAL_O,
    output logic                              IRQ_REQ_O,
    output logic                              HOLD_RELEASE_O,
    output logic                              SHARED_OUTPUT_PIN_O,
    output logic                              SHARED_OUTPUT_PIN_OE_O
);
    import bst_pkg::*;

    bst_cnt_if #(.W(BST_LO_W)) lo_if ();
    bst_cnt_if #(.W(BST_HI_W)) hi_if ();

    bst_upcnt #(.W(BST_LO_W)) u_lo (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .port_if (lo_if.cnt)
    );
    bst_upcnt #(.W(BST_HI_W)) u_hi (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .port_if (hi_if.cnt)
    );

    logic [7:0]  ctl_reg;
    logic [7:0]  ctl_next;
    logic [7:0]  sel_reg;
    logic [7:0]  sel_next;
    logic [1:0]  aux_reg;
    logic [1:0]  aux_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        irq_reg;
    logic        irq_next;
    logic        wake_reg;
    logic        wake_next;
    logic        pin_reg;
    logic        pin_next;
    logic        pin_oe_reg;
    logic        pin_oe_next;
    logic        pwm_reg;
    logic        pwm_next;

    logic        acc;
    logic        hit_ctl;
    logic        hit_sel;
    logic        hit_cnt;
    logic        hit_aux;
    logic        mapped;
    logic        wr_en;
    logic [31:0] rd_data;
    logic        src_tick;
    logic        frozen;
    logic        stopped;
    logic        adv;
    logic        fast;
    logic        run;
    logic [1:0]  p1_sel;
    logic        irq0_ev;
    logic        irq1_ev;
    logic        buzzer_select;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    assign acc     = PSEL_I & PENABLE_I;
    assign hit_ctl = (PADDR_I == BST_ADDR_CTL);
    assign hit_sel = (PADDR_I == BST_ADDR_SEL);
    assign hit_cnt = (PADDR_I == BST_ADDR_CNT);
    assign hit_aux = (PADDR_I == BST_ADDR_AUX);
    assign mapped  = hit_ctl | hit_sel | hit_cnt | hit_aux;
    // write lands only at the completing edge of the access phase
    assign wr_en   = acc & pready_reg & PWRITE_I & mapped;

    // read mux; unused upper bits read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_ctl) begin
            rd_data[7:0] = ctl_reg;
        end else if (hit_sel) begin
            rd_data[7:0] = sel_reg;
        end else if (hit_cnt) begin
            rd_data[13:0] = {hi_if.value, lo_if.value};
        end else if (hit_aux) begin
            rd_data[1:0] = aux_reg;
        end
    end

    // one wait state gives the answer a flop boundary
    always_comb begin
        pready_next  = acc & ~pready_reg;
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (acc && !pready_reg) begin
            prdata_next  = PWRITE_I ? 32'h0000_0000 : rd_data;
            pslverr_next = ~mapped;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // count source and chaining
    assign fast   = ctl_reg[BST_CTL_FAST];
    assign run    = ctl_reg[BST_CTL_RUN];
    assign p1_sel = {ctl_reg[BST_CTL_P1_HI], ctl_reg[BST_CTL_P1_LO]};
    assign buzzer_select  = sel_reg[BST_SEL_BUZ];

    // inhibited code yields no ticks rather than garbage
    always_comb begin
        case (bst_ck_t'({sel_reg[BST_SEL_CK_HI], sel_reg[BST_SEL_CK_LO]}))
            BST_CK_SUB: src_tick = SUBCLK_TICK_I;
            BST_CK_CYC: src_tick = CYCLE_TICK_I;
            BST_CK_T0:  src_tick = T0_PRESCALE_TICK_I;
            default:    src_tick = 1'b0;
        endcase
    end

    // hold freezes the count unless hold counting is allowed
    assign frozen  = XTAL_HOLD_I & ~aux_reg[BST_AUX_HOLDCNT];
    // run off: finish the lap, then park at zero
    assign stopped = ~run & (lo_if.value == '0)
                     & (hi_if.value == '0);
    assign adv     = src_tick & ~frozen & ~stopped;

    // counter clear is any write to the count register
    assign lo_if.clr  = wr_en & hit_cnt;
    assign hi_if.clr  = wr_en & hit_cnt;
    assign lo_if.tick = adv;
    assign hi_if.tick = fast ? adv : lo_if.wrap;

    // upper stage overflow: 64 ticks fast, 16384 chained
    assign irq0_ev = hi_if.wrap;

    // irq1 taps; a mid-lap period change can hit early
    always_comb begin
        case ({fast, p1_sel})
            3'h0, 3'h4: irq1_ev = adv & (&lo_if.value[4:0]);
            3'h1, 3'h5: irq1_ev = adv & (&lo_if.value[6:0]);
            3'h2:       irq1_ev = lo_if.wrap & hi_if.value[0];
            3'h3:       irq1_ev = lo_if.wrap & (&hi_if.value[2:0]);
            3'h6:       irq1_ev = adv & lo_if.value[0];
            3'h7:       irq1_ev = adv & (&lo_if.value[2:0]);
            default:    irq1_ev = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // register file; hardware set beats a software clear
    always_comb begin
        ctl_next = ctl_reg;
        sel_next = sel_reg;
        aux_next = aux_reg;
        if (wr_en && hit_ctl) begin
            ctl_next = PWDATA_I[7:0];
        end
        if (wr_en && hit_sel) begin
            sel_next = PWDATA_I[7:0];
        end
        if (wr_en && hit_aux) begin
            aux_next = PWDATA_I[1:0];
        end
        if (irq1_ev) begin
            ctl_next[BST_CTL_IF1] = 1'b1;
        end
        if (irq0_ev) begin
            ctl_next[BST_CTL_IF0] = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ctl_reg <= BST_CTL_RST;
            sel_reg <= BST_SEL_RST;
            aux_reg <= BST_AUX_RST;
        end else begin
            ctl_reg <= ctl_next;
            sel_reg <= sel_next;
            aux_reg <= aux_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // requests and the shared pin, all registered
    always_comb begin
        irq_next    = (ctl_reg[BST_CTL_IE1] & ctl_reg[BST_CTL_IF1])
                    | (ctl_reg[BST_CTL_IE0] & ctl_reg[BST_CTL_IF0]);
        wake_next   = irq_next;
        // buzzer tap is the count clock divided by eight
        pwm_next    = buzzer_select ? 1'b1 : HIGH_SIDE_PWM_SIGNAL_I;
        pin_next    = buzzer_select ? lo_if.value[BST_BUZ_TAP]
                            : HIGH_SIDE_PWM_SIGNAL_I;
        pin_oe_next = aux_reg[BST_AUX_PINFN];
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            irq_reg    <= 1'b0;
            wake_reg   <= 1'b0;
            pwm_reg    <= 1'b1;
            pin_reg    <= 1'b1;
            pin_oe_reg <= 1'b0;
        end else begin
            irq_reg    <= irq_next;
            wake_reg   <= wake_next;
            pwm_reg    <= pwm_next;
            pin_reg    <= pin_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign PRDATA_O               = prdata_reg;
    assign PREADY_O               = pready_reg;
    assign PSLVERR_O              = pslverr_reg;
    assign IRQ_REQ_O              = irq_reg;
    assign HOLD_RELEASE_O         = wake_reg;
    assign HIGH_SIDE_PWM_SIGNAL_O = pwm_reg;
    assign SHARED_OUTPUT_PIN_O    = pin_reg;
    assign SHARED_OUTPUT_PIN_OE_O = pin_oe_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_chain;
        (!fast && hi_if.tick) |-> lo_if.wrap && (&lo_if.value);
    endproperty
    a_chain: assert property (p_chain)
        else $error("upper stage ticked without lower overflow");

    property p_irq0_set;
        (irq0_ev && fast) |-> (hi_if.value == 6'h3f) ##1 ctl_reg[BST_CTL_IF0];
    endproperty
    a_irq0_set: assert property (p_irq0_set)
        else $error("fast overflow did not set irq0 flag");

    property p_irq0_slow;
        (irq0_ev && !fast) |-> ({hi_if.value, lo_if.value} == 14'h3fff);
    endproperty
    a_irq0_slow: assert property (p_irq0_slow)
        else $error("slow irq0 not at 14-bit overflow");

    property p_park;
        (stopped && !lo_if.clr) |=> lo_if.value == '0 && hi_if.value == '0;
    endproperty
    a_park: assert property (p_park)
        else $error("stopped timer left zero");

    property p_p512;
        (!fast && p1_sel == 2'h2 && lo_if.wrap) |-> irq1_ev == hi_if.value[0];
    endproperty
    a_p512: assert property (p_p512)
        else $error("512 period tap wrong");

    property p_p2;
        (fast && p1_sel == 2'h2 && adv) |-> irq1_ev == lo_if.value[0];
    endproperty
    a_p2: assert property (p_p2)
        else $error("2 period tap wrong");

    property p_if1_sticky;
        (ctl_reg[BST_CTL_IF1] && !(wr_en && hit_ctl)) |=> ctl_reg[BST_CTL_IF1];
    endproperty
    a_if1_sticky: assert property (p_if1_sticky)
        else $error("irq1 flag dropped without a write");

    property p_set_wins;
        (irq0_ev && wr_en && hit_ctl) |=> ctl_reg[BST_CTL_IF0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("irq0 event lost to a clear");

    property p_req;
        (ctl_reg[BST_CTL_IE1] && ctl_reg[BST_CTL_IF1])
            |=> IRQ_REQ_O && HOLD_RELEASE_O;
    endproperty
    a_req: assert property (p_req)
        else $error("enabled irq1 flag raised no request");

    property p_req0;
        (ctl_reg[BST_CTL_IE0] && ctl_reg[BST_CTL_IF0])
            |=> IRQ_REQ_O && HOLD_RELEASE_O;
    endproperty
    a_req0: assert property (p_req0)
        else $error("enabled irq0 flag raised no request");

    property p_buz;
        buzzer_select |=> HIGH_SIDE_PWM_SIGNAL_O
              && SHARED_OUTPUT_PIN_O == $past(lo_if.value[BST_BUZ_TAP]);
    endproperty
    a_buz: assert property (p_buz)
        else $error("buzzer mode output wrong");

    property p_nobuz;
        !buzzer_select |=> SHARED_OUTPUT_PIN_O == $past(HIGH_SIDE_PWM_SIGNAL_I);
    endproperty
    a_nobuz: assert property (p_nobuz)
        else $error("pwm not passed to pin");

    property p_freeze;
        (XTAL_HOLD_I && !aux_reg[BST_AUX_HOLDCNT]) |-> !lo_if.tick;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counted in hold without permission");

    c_irq0:  cover property (irq0_ev);
    c_irq1:  cover property (irq1_ev && fast);
    c_buz:   cover property (buzzer_select && SHARED_OUTPUT_PIN_OE_O);
    c_stop:  cover property (!run && adv ##1 stopped);
endmodule
`default_nettype wire

// file: sim/bst_timer_test.sv
// Purpose: self-checking bench for the interval timer over APB
// Assumes: count ticks are one-cycle pulses, slave answers on pready
// Notes:   ticks are spaced one idle cycle apart to stay unambiguous
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
    begin \
        num_checks++; \
        if ((act) !== (exp)) begin \
            fail_count++; \
            $display("[FAIL] t=%0t got %0h want %0h", $time, act, exp); \
        end \
    end
module bst_timer_test;
    import bst_pkg::*;
    logic              clk       = 1'b0;
    logic              rst_n     = 1'b0;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [BST_AW-1:0] paddr     = '0;
    logic [31:0]       pwdata    = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              sub       = 1'b0;
    logic              cyc       = 1'b0;
    logic              t0        = 1'b0;
    logic              xtal_hold = 1'b0;
    logic              pwm_in    = 1'b0;
    logic              pwm_out;
    logic              irq_req;
    logic              hold_rel;
    logic              pin;
    logic              pin_oe;
    logic [31:0]       rv;
    logic              ev;
    int                fail_count = 0;
    int                num_checks = 0;

    bst_timer dut (
        .REF_CLK_I              (clk),
        .RST_N_I                (rst_n),
        .PSEL_I                 (psel),
        .PENABLE_I              (penable),
        .PWRITE_I               (pwrite),
        .PADDR_I                (paddr),
        .PWDATA_I               (pwdata),
        .PRDATA_O               (prdata),
        .PREADY_O               (pready),
        .PSLVERR_O              (pslverr),
        .SUBCLK_TICK_I          (sub),
        .CYCLE_TICK_I           (cyc),
        .T0_PRESCALE_TICK_I     (t0),
        .XTAL_HOLD_I            (xtal_hold),
        .HIGH_SIDE_PWM_SIGNAL_I (pwm_in),
        .HIGH_SIDE_PWM_SIGNAL_O (pwm_out),
        .IRQ_REQ_O              (irq_req),
        .HOLD_RELEASE_O         (hold_rel),
        .SHARED_OUTPUT_PIN_O    (pin),
        .SHARED_OUTPUT_PIN_OE_O (pin_oe)
    );

    // 20 MHz reference
    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // one apb transfer, plus an idle cycle so calls never collide
    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [17:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // n count pulses on one source: 0 sub, 1 cycle, else timer 0
    // idle cycle between pulses keeps cycle period within half
    task automatic tick(input int n, input logic [1:0] s);
        repeat (n) begin
            case (s)
                2'h0: sub <= 1'b1;
                2'h1: cyc <= 1'b1;
                default: t0 <= 1'b1;
            endcase
            @(posedge clk);
            sub <= 1'b0;
            cyc <= 1'b0;
            t0 <= 1'b0;
            @(posedge clk);
        end
    endtask

    // second control write drops any flag raised by the clear
    task automatic setup(input logic [7:0] ctl);
        wr(BST_ADDR_CTL, ctl);
        wr(BST_ADDR_CNT, 8'h00);
        wr(BST_ADDR_CTL, ctl);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_regs();
        logic [17:0] regs [4];
        regs = '{BST_ADDR_SEL, BST_ADDR_CTL, BST_ADDR_CNT, BST_ADDR_AUX};
        `CHK({pwm_out, pin, pin_oe, irq_req, hold_rel}, 5'b11000);
        for (int i = 0; i < 4; i++) begin
            rd(regs[i]);
            `CHK({ev, rv}, 33'h0);
        end
        wr(BST_ADDR_SEL, 8'hc7);
        rd(BST_ADDR_SEL);
        `CHK(rv, 32'hc7);
        apb(1'b1, 18'h0, 32'hff);
        `CHK(ev, 1'b1);
        apb(1'b0, 18'h0, 32'h0);
        `CHK({ev, rv}, {1'b1, 32'h0});
        wr(BST_ADDR_SEL, 8'h00);
    endtask

    task automatic t_clock_sel();
        logic [13:0] want;
        for (int s = 0; s < 4; s++) begin
            wr(BST_ADDR_CNT, 8'h00);
            wr(BST_ADDR_CTL, 8'h00);
            // inhibited code is never written; slot 2 checks t0 is ignored
            wr(BST_ADDR_SEL, {2'h0, (s == 2) ? 2'h0 : s[1:0], 4'h0});
            wr(BST_ADDR_CTL, 8'h40);
            tick(300, s[1:0]);
            tick(7, (s == 0) ? 2'h1 : 2'h0);
            want = (s == 2) ? 14'h0007 : 14'h012c;
            rd(BST_ADDR_CNT);
            `CHK(rv[13:0], want);
        end
        wr(BST_ADDR_CNT, 8'h00);
        wr(BST_ADDR_CTL, 8'h00);
        wr(BST_ADDR_SEL, 8'h00);
    endtask

    task automatic t_irq1_periods();
        int per [8];
        per = '{32, 128, 512, 2048, 32, 128, 2, 8};
        for (int i = 0; i < 8; i++) begin
            setup({i[2], 1'b1, i[1:0], 4'h4});
            tick(per[i] - 1, 2'h0);
            rd(BST_ADDR_CTL);
            `CHK({rv[3], irq_req}, 2'b00);
            tick(1, 2'h0);
            rd(BST_ADDR_CTL);
            `CHK({rv[3], irq_req}, 2'b11);
        end
    endtask

    task automatic t_irq0();
        for (int f = 1; f >= 0; f--) begin
            setup({f[0], 1'b1, 2'h0, 4'h1});
            tick(f ? 63 : 16383, 2'h0);
            rd(BST_ADDR_CTL);
            `CHK({rv[1], irq_req}, 2'b00);
            // flag clear lands on the wrapping tick: the set must win
            fork
                wr(BST_ADDR_CTL, {f[0], 1'b1, 2'h0, 4'h1});
                begin
                    repeat (2) @(posedge clk);
                    tick(1, 2'h0);
                end
            join
            repeat (2) @(posedge clk);
            `CHK({irq_req, hold_rel}, 2'b11);
            rd(BST_ADDR_CTL);
            `CHK(rv[1], 1'b1);
            // enable off with the flag kept: request must drop
            wr(BST_ADDR_CTL, rv[7:0] & 8'hfe);
            // request flop lags the register write by one edge
            @(posedge clk);
            `CHK(irq_req, 1'b0);
            wr(BST_ADDR_CTL, {f[0], 7'h41});
            rd(BST_ADDR_CTL);
            `CHK({rv[1], irq_req}, 2'b00);
        end
    endtask

    task automatic t_run_stop();
        setup(8'hc0);
        tick(10, 2'h0);
        wr(BST_ADDR_CTL, 8'h80);
        tick(245, 2'h0);
        rd(BST_ADDR_CNT);
        `CHK(rv[13:0], 14'h3fff);
        tick(21, 2'h0);
        rd(BST_ADDR_CNT);
        `CHK(rv[13:0], 14'h0000);
        wr(BST_ADDR_CTL, 8'hc0);
        tick(3, 2'h0);
        rd(BST_ADDR_CNT);
        `CHK(rv[13:0], 14'h0303);
    endtask

    task automatic t_hold();
        // stop first, then count on the cycle clock while in hold
        wr(BST_ADDR_CTL, 8'h00);
        wr(BST_ADDR_CNT, 8'h00);
        wr(BST_ADDR_SEL, 8'h10);
        setup(8'hc0);
        xtal_hold <= 1'b1;
        tick(5, 2'h1);
        rd(BST_ADDR_CNT);
        `CHK(rv[13:0], 14'h0000);
        wr(BST_ADDR_AUX, 8'h01);
        tick(5, 2'h1);
        rd(BST_ADDR_CNT);
        `CHK(rv[13:0], 14'h0505);
        xtal_hold <= 1'b0;
        wr(BST_ADDR_AUX, 8'h00);
        wr(BST_ADDR_CTL, 8'h00);
        wr(BST_ADDR_CNT, 8'h00);
        wr(BST_ADDR_SEL, 8'h00);
    endtask

    task automatic t_buzzer();
        wr(BST_ADDR_CNT, 8'h00);
        wr(BST_ADDR_CTL, 8'h00);
        wr(BST_ADDR_SEL, 8'h08);
        wr(BST_ADDR_AUX, 8'h02);
        wr(BST_ADDR_CTL, 8'h40);
        `CHK({pwm_out, pin_oe, pin}, 3'b110);
        tick(4, 2'h0);
        repeat (2) @(posedge clk);
        `CHK(pin, 1'b1);
        tick(4, 2'h0);
        repeat (2) @(posedge clk);
        `CHK(pin, 1'b0);
        wr(BST_ADDR_SEL, 8'h00);
        pwm_in <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({pwm_out, pin}, 2'b11);
        pwm_in <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({pwm_out, pin}, 2'b00);
        wr(BST_ADDR_AUX, 8'h00);
        // enable flop lags the register write by one edge
        @(posedge clk);
        `CHK(pin_oe, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence, reset held for 16 cycles
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_regs();
        t_clock_sel();
        t_irq1_periods();
        t_irq0();
        t_run_stop();
        t_hold();
        t_buzzer();
        complete_run();
    end

    // run needs about 42k cycles; cut a hang well past that
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
